// File: src/mtd_pkg.sv
// Purpose: shared constants and types of the module thermal and descriptor slave
// Assumes: 40 MHz system clock, APB register access, serial link sampled by CLK_I
// Notes: serial register pointers and APB offsets are fixed here only
package mtd_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned SCL_MAX_HZ = 1_000_000;
    // fewest system clocks per serial clock period at the top rate
    localparam int unsigned SCL_MIN_CYC = CLK_HZ / SCL_MAX_HZ;

    // ----------------------------------------------------------------
    // serial device addresses (7 bit)
    // ----------------------------------------------------------------
    localparam logic [6:0] SENSOR_DEV_ADDR = 7'h18;
    // descriptor answers on two addresses, bit 0 picks the upper 256 bytes
    localparam logic [6:0] DESC_DEV_ADDR = 7'h50;
    localparam logic [6:0] DESC_DEV_MASK = 7'h7E;

    // ----------------------------------------------------------------
    // sensor register pointers and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] PTR_CFG = 8'h00;
    localparam logic [7:0] PTR_HIGH = 8'h01;
    localparam logic [7:0] PTR_CRIT = 8'h02;
    localparam logic [7:0] PTR_HYST = 8'h03;
    localparam logic [7:0] PTR_TEMP = 8'h04;
    localparam int unsigned CFG_MODE_LSB = 0;
    localparam int unsigned CFG_EVT_EN_BIT = 2;
    localparam int unsigned CFG_CLR_BIT = 3;
    localparam int unsigned CFG_STAT_BIT = 4;
    localparam logic [7:0] HIGH_RST = 8'h50;
    localparam logic [7:0] CRIT_RST = 8'h5F;
    localparam logic [7:0] HYST_RST = 8'h02;
    localparam logic [7:0] TEMP_RST = 8'h00;

    // ----------------------------------------------------------------
    // descriptor map
    // ----------------------------------------------------------------
    localparam int unsigned DESC_BYTES = 512;
    localparam logic [8:0] RSVD_FIRST = 9'h100;
    localparam logic [8:0] RSVD_LAST = 9'h13F;
    localparam logic [8:0] PROT_LAST = 9'h17F;
    localparam logic [7:0] RSVD_FILL = 8'h00;

    // ----------------------------------------------------------------
    // APB map
    // ----------------------------------------------------------------
    localparam logic [7:0] APB_CTRL = 8'h00;
    localparam logic [7:0] APB_IRQ_STAT = 8'h04;
    localparam logic [7:0] APB_IRQ_MASK = 8'h08;
    localparam logic [7:0] APB_TEMP = 8'h0C;
    localparam int unsigned CTRL_SWP_BIT = 0;

    typedef enum logic [1:0] {
        MTD_MODE_INT,
        MTD_MODE_CMP,
        MTD_MODE_CRIT
    } mtd_mode_e;

    // interrupt sources, same layout in status and mask
    typedef struct packed {
        logic refused;
        logic wr_done;
        logic alert;
    } mtd_evt_s;

    typedef struct packed {
        logic evt_en;
        mtd_mode_e mode;
    } mtd_cfg_s;

endpackage : mtd_pkg

// File: src/mtd_thermal_desc.sv
// Purpose: thermal sensor with open-drain alert and 512-byte descriptor store on a serial slave
// Assumes: SCL/SDA arrive from another domain, temperature samples from on-chip logic
// Notes: serial link sampled by CLK_I, APB gives protection control and interrupts
// What this block does
// - refresh temperature register on every new sample
// - temperature register readable at any time
// - drive active-low open-drain alert output
// - descriptor logic never touches the alert
// - three alert modes: interrupt, comparator, critical-only
// - interrupt mode holds alert until clear written
// - comparator mode releases alert when condition ends
// - critical compare always behaves as comparator
// - critical-only asserts above limit, releases below hysteresis
// - 512 bytes in four 128-byte blocks, the lower three protectable
// - blocks zero and one hold device/module parameters
// - reserved range 100h-13Fh reads zero
// - lower 384 preloaded, upper 128 user data
// - serial slave only, timed by master clock
// - serial clock up to 1 MHz
// - protection refuses writes to bytes 0-383
// - upper 128 bytes always writable
// - descriptor reachable only over serial bus
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
module mtd_thermal_desc
    import mtd_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    output logic EVENT_N_O,
    output logic EVENT_N_OE_O,
    input wire logic [7:0] TEMP_I,
    input wire logic TEMP_VALID_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic IRQ_O
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } mtd_st_e;

    // ----------------------------------------------------------------
    // serial pin synchronisers and edge detect
    // ----------------------------------------------------------------
    logic [1:0] scl_sync_ff;
    logic [1:0] sda_sync_ff;
    logic scl_d_ff;
    logic sda_d_ff;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], SCL_I};
            sda_sync_ff <= {sda_sync_ff[0], SDA_I};
            scl_d_ff <= scl_sync_ff[1];
            sda_d_ff <= sda_sync_ff[1];
        end
    end

    wire scl = scl_sync_ff[1];
    wire sda = sda_sync_ff[1];
    // all bus timing follows the master clock edges
    wire scl_rise = scl & ~scl_d_ff;
    wire scl_fall = ~scl & scl_d_ff;
    wire bus_start = scl & scl_d_ff & sda_d_ff & ~sda;
    wire bus_stop = scl & scl_d_ff & ~sda_d_ff & sda;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    mtd_st_e st_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] tx_ff;
    logic rw_ff;
    logic dev_desc_ff;
    logic first_ff;
    logic ack_ok_ff;
    logic sda_oe_ff;
    logic [8:0] addr_ff;
    logic [7:0] ptr_ff;
    mtd_cfg_s cfg_ff;
    logic [7:0] high_ff;
    logic [7:0] crit_ff;
    logic [7:0] hyst_ff;
    logic [7:0] temp_ff;
    logic int_latch_ff;
    logic crit_hold_ff;
    logic alert_ff;
    logic swp_ff;
    mtd_evt_s stat_ff;
    mtd_evt_s mask_ff;
    logic [31:0] prdata_ff;
    logic [7:0] mem [0:DESC_BYTES-1];

    // ----------------------------------------------------------------
    // address match and byte decode
    // ----------------------------------------------------------------
    wire [6:0] rx_dev = shift_ff[7:1];
    wire hit_sensor = (rx_dev == SENSOR_DEV_ADDR);
    wire hit_desc = ((rx_dev & DESC_DEV_MASK) == DESC_DEV_ADDR);
    wire byte_done = (bit_cnt_ff == 4'h8);
    // reserved span reads as fill and takes no write
    wire in_rsvd = (addr_ff >= RSVD_FIRST) && (addr_ff <= RSVD_LAST);
    // lower 384 bytes under protection, upper block never
    wire in_prot = (addr_ff <= PROT_LAST);
    wire wr_refused = in_rsvd | (swp_ff & in_prot);
    wire rx_data = (st_ff == ST_RX) && scl_fall && byte_done && !first_ff;
    wire desc_wr = rx_data && dev_desc_ff && !wr_refused;
    wire desc_ref = rx_data && dev_desc_ff && wr_refused;
    wire sens_wr = rx_data && !dev_desc_ff;
    // clear bit acts only when written as one
    wire clr_evt = sens_wr && (ptr_ff == PTR_CFG) && shift_ff[CFG_CLR_BIT];

    logic [7:0] sens_rd;
    always_comb begin
        case (ptr_ff)
            PTR_CFG: sens_rd = {3'h0, alert_ff, 1'b0, cfg_ff};
            PTR_HIGH: sens_rd = high_ff;
            PTR_CRIT: sens_rd = crit_ff;
            PTR_HYST: sens_rd = hyst_ff;
            PTR_TEMP: sens_rd = temp_ff;
            default: sens_rd = 8'h00;
        endcase
    end

    // descriptor reads through the serial bus only
    wire [7:0] desc_rd = in_rsvd ? RSVD_FILL : mem[addr_ff];
    wire [7:0] rd_byte = dev_desc_ff ? desc_rd : sens_rd;

    // ----------------------------------------------------------------
    // serial slave sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_ff <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            tx_ff <= 8'h00;
            rw_ff <= 1'b0;
            dev_desc_ff <= 1'b0;
            first_ff <= 1'b0;
            ack_ok_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            addr_ff <= 9'h000;
            ptr_ff <= PTR_TEMP;
        end else if (bus_stop) begin
            st_ff <= ST_IDLE;
            sda_oe_ff <= 1'b0;
        end else if (bus_start) begin
            st_ff <= ST_ADDR;
            bit_cnt_ff <= 4'h0;
            first_ff <= 1'b1;
            sda_oe_ff <= 1'b0;
        end else begin
            case (st_ff)
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        shift_ff <= {shift_ff[6:0], sda};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        bit_cnt_ff <= 4'h0;
                        if (st_ff == ST_RX) begin
                            st_ff <= ST_RX_ACK;
                            sda_oe_ff <= 1'b1;
                            first_ff <= 1'b0;
                            if (first_ff && dev_desc_ff) begin
                                addr_ff[7:0] <= shift_ff;
                            end else if (first_ff) begin
                                ptr_ff <= shift_ff;
                            end else if (dev_desc_ff) begin
                                addr_ff <= addr_ff + 9'h001;
                            end
                        end else if (hit_sensor || hit_desc) begin
                            st_ff <= ST_ADDR_ACK;
                            sda_oe_ff <= 1'b1;
                            rw_ff <= shift_ff[0];
                            dev_desc_ff <= hit_desc;
                            if (hit_desc) begin
                                addr_ff[8] <= shift_ff[1];
                            end
                        end else begin
                            st_ff <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_RX_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_ff <= 4'h0;
                        if (st_ff == ST_ADDR_ACK && rw_ff) begin
                            st_ff <= ST_TX;
                            tx_ff <= rd_byte;
                            sda_oe_ff <= ~rd_byte[7];
                            if (dev_desc_ff) begin
                                addr_ff <= addr_ff + 9'h001;
                            end
                        end else begin
                            st_ff <= ST_RX;
                            sda_oe_ff <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                        st_ff <= ST_TX_ACK;
                        sda_oe_ff <= 1'b0;
                    end else if (scl_fall) begin
                        tx_ff <= {tx_ff[6:0], 1'b0};
                        sda_oe_ff <= ~tx_ff[6];
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        ack_ok_ff <= ~sda;
                    end else if (scl_fall && ack_ok_ff) begin
                        st_ff <= ST_TX;
                        bit_cnt_ff <= 4'h0;
                        tx_ff <= rd_byte;
                        sda_oe_ff <= ~rd_byte[7];
                        if (dev_desc_ff) begin
                            addr_ff <= addr_ff + 9'h001;
                        end
                    end else if (scl_fall) begin
                        st_ff <= ST_IDLE;
                    end
                end
                default: begin
                    st_ff <= ST_IDLE;
                    sda_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // descriptor array, filled over the serial bus
    // ----------------------------------------------------------------
    // contents hold across reset; the lower 384 bytes are loaded in
    // production and protected, 180h-1FFh stay for the user
    always_ff @(posedge CLK_I) begin
        if (desc_wr) begin
            mem[addr_ff] <= shift_ff;
        end
    end

    // ----------------------------------------------------------------
    // sensor registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cfg_ff <= '{evt_en: 1'b0, mode: MTD_MODE_INT};
            high_ff <= HIGH_RST;
            crit_ff <= CRIT_RST;
            hyst_ff <= HYST_RST;
            temp_ff <= TEMP_RST;
        end else begin
            if (TEMP_VALID_I) begin
                temp_ff <= TEMP_I;
            end
            if (sens_wr) begin
                case (ptr_ff)
                    PTR_CFG: cfg_ff <= shift_ff[CFG_EVT_EN_BIT:CFG_MODE_LSB];
                    PTR_HIGH: high_ff <= shift_ff;
                    PTR_CRIT: crit_ff <= shift_ff;
                    PTR_HYST: hyst_ff <= shift_ff;
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // alert decision
    // ----------------------------------------------------------------
    wire above_high = (temp_ff > high_ff);
    wire above_crit = (temp_ff > crit_ff);
    wire [8:0] temp_plus_hyst = {1'b0, temp_ff} + {1'b0, hyst_ff};
    wire below_rel = (temp_plus_hyst < {1'b0, crit_ff});

    logic alert_lvl;
    always_comb begin
        case (cfg_ff.mode)
            MTD_MODE_INT: alert_lvl = int_latch_ff | crit_hold_ff;
            MTD_MODE_CMP: alert_lvl = above_high | crit_hold_ff;
            MTD_MODE_CRIT: alert_lvl = crit_hold_ff;
            default: alert_lvl = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            int_latch_ff <= 1'b0;
            crit_hold_ff <= 1'b0;
            alert_ff <= 1'b0;
        end else begin
            // a new excursion wins over a clear in the same cycle
            int_latch_ff <= above_high | (int_latch_ff & ~clr_evt);
            if (above_crit) begin
                crit_hold_ff <= 1'b1;
            end else if (below_rel) begin
                crit_hold_ff <= 1'b0;
            end
            alert_ff <= alert_lvl & cfg_ff.evt_en;
        end
    end

    // open drain: the pin is only ever pulled low
    assign EVENT_N_O = 1'b0;
    assign EVENT_N_OE_O = alert_ff;
    assign SDA_O = 1'b0;
    assign SDA_OE_O = sda_oe_ff;

    // ----------------------------------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------------------------------
    wire apb_setup = PSEL_I & ~PENABLE_I;
    wire apb_acc = PSEL_I & PENABLE_I;
    wire sel_ctrl = (PADDR_I == APB_CTRL);
    wire sel_stat = (PADDR_I == APB_IRQ_STAT);
    wire sel_mask = (PADDR_I == APB_IRQ_MASK);
    wire sel_temp = (PADDR_I == APB_TEMP);
    wire apb_hit = sel_ctrl | sel_stat | sel_mask | sel_temp;
    wire apb_wr = apb_acc & PWRITE_I;
    wire [2:0] stat_clr = (apb_wr & sel_stat) ? PWDATA_I[2:0] : 3'h0;
    wire alert_rise = alert_lvl & cfg_ff.evt_en & ~alert_ff;
    wire [2:0] evt_new = {desc_ref, desc_wr, alert_rise};

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_ctrl) begin
            rd_mux[CTRL_SWP_BIT] = swp_ff;
        end else if (sel_stat) begin
            rd_mux[2:0] = stat_ff;
        end else if (sel_mask) begin
            rd_mux[2:0] = mask_ff;
        end else if (sel_temp) begin
            rd_mux[7:0] = temp_ff;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            swp_ff <= 1'b0;
            stat_ff <= '0;
            mask_ff <= '0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            // events set, a one written clears, set wins
            stat_ff <= evt_new | (stat_ff & ~stat_clr);
            if (apb_wr && sel_ctrl) begin
                swp_ff <= PWDATA_I[CTRL_SWP_BIT];
            end
            if (apb_wr && sel_mask) begin
                mask_ff <= PWDATA_I[2:0];
            end
            if (apb_setup && !PWRITE_I) begin
                prdata_ff <= rd_mux;
            end
        end
    end

    assign PRDATA_O = prdata_ff;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = apb_acc & ~apb_hit;
    assign IRQ_O = |(stat_ff & mask_ff);

endmodule : mtd_thermal_desc

// File: testbench/mtd_i2c_host.sv
// Purpose: behavioural serial bus master facing the thermal and descriptor slave
// Assumes: data wire pulled up and resolved in the bench
// Notes: clock stands high between frames, bit time 200 ns
module mtd_i2c_host (
    output logic scl_o,
    output logic sda_low_o,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // quarter bit of the 200 ns bench link clock
    localparam int QTR = 50;

    initial begin
        scl_o = 1'h1;
        sda_low_o = 1'h0;
    end

    // data moves a quarter bit after the clock falls
    task automatic bit_out(input logic b);
        #QTR sda_low_o = ~b;
        #QTR scl_o = 1'h1;
        #(2 * QTR) scl_o = 1'h0;
    endtask : bit_out

    task automatic bit_in(output logic b);
        #QTR sda_low_o = 1'h0;
        #QTR scl_o = 1'h1;
        #QTR b = sda_i;
        #QTR scl_o = 1'h0;
    endtask : bit_in

    // releases data, raises the clock, then pulls data low for a start; the offset keeps clock edges off system edges
    task automatic start;
        #(QTR + 7) sda_low_o = 1'h0;
        #QTR scl_o = 1'h1;
        #QTR sda_low_o = 1'h1;
        #QTR scl_o = 1'h0;
    endtask : start

    task automatic stop;
        #QTR sda_low_o = 1'h1;
        #QTR scl_o = 1'h1;
        #QTR sda_low_o = 1'h0;
        #QTR;
    endtask : stop

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(b);
        ack = ~b;
    endtask : put_byte

    task automatic get_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(last);
    endtask : get_byte
endmodule : mtd_i2c_host

// File: testbench/mtd_thermal_desc_assertions.sv
// Purpose: port-level checks of the thermal and descriptor slave
// Assumes: one clock domain, reset active high
// Notes: bound to every instance of the top module
module mtd_thermal_desc_chk
    import mtd_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic SCL_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_O,
    input wire logic EVENT_N_O,
    input wire logic EVENT_N_OE_O,
    input wire logic [7:0] TEMP_I,
    input wire logic TEMP_VALID_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PSLVERR_O,
    input wire logic IRQ_O
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] temp_seen_ff;
    wire logic mapped = PADDR_I inside {APB_CTRL, APB_IRQ_STAT, APB_IRQ_MASK, APB_TEMP};
    wire logic rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    // last sample handed in, for the read-back check
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            temp_seen_ff <= 8'h00;
        end else if (TEMP_VALID_I) begin
            temp_seen_ff <= TEMP_I;
        end
    end

    a_alert_value_low: assert property (EVENT_N_O == 1'h0)
        else $error("alert pin value not low");
    a_data_value_low: assert property (SDA_O == 1'h0)
        else $error("data pin value not low");
    a_temp_readback: assert property (
        rd_setup && PADDR_I == APB_TEMP |=> PRDATA_O == {24'h000000, $past(temp_seen_ff)})
        else $error("temperature read differs from last sample");
    a_rdata_holds: assert property (!rd_setup |=> $stable(PRDATA_O))
        else $error("read data moved without a read");
    a_sda_scl_low: assert property ($changed(SDA_OE_O) |-> !$past(SCL_I, 2))
        else $error("data pin changed while serial clock high");
    a_err_unmapped: assert property (PSLVERR_O == (PSEL_I && PENABLE_I && !mapped))
        else $error("error response not tied to unmapped access");
    a_irq_drop_cause: assert property ($fell(IRQ_O) |-> $past(PSEL_I && PENABLE_I && PWRITE_I))
        else $error("interrupt dropped without a register write");
    a_quiet_after_rst: assert property ($fell(RST_I) |-> !SDA_OE_O && !EVENT_N_OE_O && !IRQ_O)
        else $error("outputs active right after reset");
endmodule : mtd_thermal_desc_chk

bind mtd_thermal_desc mtd_thermal_desc_chk i_mtd_thermal_desc_chk (
    .CLK_I, .RST_I, .SCL_I, .SDA_O, .SDA_OE_O, .EVENT_N_O, .EVENT_N_OE_O, .TEMP_I,
    .TEMP_VALID_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PRDATA_O, .PSLVERR_O, .IRQ_O
);

// File: testbench/mtd_thermal_desc_tb_top.sv
// Purpose: self-checking bench of the thermal and descriptor slave
// Assumes: pull-ups on both open-drain wires
// Notes: descriptor cases and alert steps run from tables
module mtd_thermal_desc_tb_top
    import mtd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic prot;
        logic [8:0] addr;
        logic [7:0] wd;
        logic [7:0] rd;
    } mtd_drow_s;
    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] val;
        logic [7:0] temp;
        logic alert;
    } mtd_arow_s;
    // protect flag, address, written byte, byte read back
    localparam mtd_drow_s DROWS [9] = '{{1'h0, 9'h010, 8'hA5, 8'hA5},
        {1'h0, 9'h0F0, 8'h3C, 8'h3C}, {1'h0, 9'h120, 8'hFF, 8'h00},
        {1'h0, 9'h13F, 8'h55, 8'h00}, {1'h0, 9'h17F, 8'h11, 8'h11},
        {1'h1, 9'h010, 8'h5A, 8'hA5}, {1'h1, 9'h17F, 8'h22, 8'h11},
        {1'h1, 9'h180, 8'h33, 8'h33}, {1'h1, 9'h1FF, 8'h44, 8'h44}};
    // sensor pointer, value, next temperature, alert expected
    localparam mtd_arow_s AROWS [14] = '{{PTR_CFG, 8'h04, 8'h2A, 1'h0},
        {PTR_HIGH, 8'h40, 8'h45, 1'h1}, {PTR_HYST, 8'h02, 8'h30, 1'h1},
        {PTR_CFG, 8'h04, 8'h30, 1'h1}, {PTR_CFG, 8'h0C, 8'h30, 1'h0},
        {PTR_CFG, 8'h05, 8'h45, 1'h1}, {PTR_HYST, 8'h02, 8'h30, 1'h0},
        {PTR_CFG, 8'h06, 8'h45, 1'h0}, {PTR_HYST, 8'h02, 8'h60, 1'h1},
        {PTR_HYST, 8'h02, 8'h5D, 1'h1}, {PTR_HYST, 8'h02, 8'h5C, 1'h0},
        {PTR_HIGH, 8'h70, 8'h30, 1'h0}, {PTR_CFG, 8'h0C, 8'h60, 1'h1},
        {PTR_HYST, 8'h02, 8'h30, 1'h0}};
    logic clk = 1'h0, rst = 1'h1, temp_vld = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] temp = 8'h00, paddr = 8'h00, rd_b;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic scl, sda_low, sda_o, sda_oe, ev_o, ev_oe, pready, pslverr, irq, rd_err;
    int err_count = 0, n_compared = 0, cycles = 0;
    wire logic sda_w = !(sda_low || sda_oe);
    wire logic ev_w = !ev_oe;

    mtd_thermal_desc i_mtd_thermal_desc (.CLK_I(clk), .RST_I(rst), .SCL_I(scl),
        .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .EVENT_N_O(ev_o),
        .EVENT_N_OE_O(ev_oe), .TEMP_I(temp), .TEMP_VALID_I(temp_vld), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq));
    mtd_i2c_host i_mtd_i2c_host (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_w));

    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            test_done();
        end
    end

    // ------
    // tasks
    // ------
    task automatic test_done;
        if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd_q = prdata;
        rd_err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic ser_wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
        logic ack;
        i_mtd_i2c_host.start();
        i_mtd_i2c_host.put_byte({dev, 1'h0}, ack);
        i_mtd_i2c_host.put_byte(a, ack);
        i_mtd_i2c_host.put_byte(d, ack);
        i_mtd_i2c_host.stop();
        check("data ack", 32'h1, 32'(ack));
    endtask : ser_wr

    task automatic ser_rd(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] q);
        logic ack;
        i_mtd_i2c_host.start();
        i_mtd_i2c_host.put_byte({dev, 1'h0}, ack);
        i_mtd_i2c_host.put_byte(a, ack);
        i_mtd_i2c_host.start();
        i_mtd_i2c_host.put_byte({dev, 1'h1}, ack);
        i_mtd_i2c_host.get_byte(1'h1, q);
        i_mtd_i2c_host.stop();
    endtask : ser_rd

    task automatic set_temp(input logic [7:0] t);
        @(posedge clk);
        temp <= t;
        temp_vld <= 1'h1;
        @(posedge clk);
        temp_vld <= 1'h0;
        repeat (4) @(posedge clk);
    endtask : set_temp

    // ------
    // sequence
    // ------
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            apb(1'h0, 8'(4 * i), 32'h0);
            check("reset value", 32'h0, rd_q);
        end
        apb(1'h0, 8'h10, 32'h0);
        check("unmapped error", 32'h1, 32'(rd_err));
        foreach (DROWS[i]) begin
            apb(1'h1, APB_CTRL, 32'(DROWS[i].prot));
            ser_wr({DESC_DEV_ADDR[6:1], DROWS[i].addr[8]}, DROWS[i].addr[7:0], DROWS[i].wd);
            ser_rd({DESC_DEV_ADDR[6:1], DROWS[i].addr[8]}, DROWS[i].addr[7:0], rd_b);
            check("descriptor byte", 32'(DROWS[i].rd), 32'(rd_b));
        end
        apb(1'h0, APB_IRQ_STAT, 32'h0);
        check("write events", 32'h6, rd_q);
        apb(1'h1, APB_IRQ_STAT, 32'h7);
        apb(1'h0, APB_IRQ_STAT, 32'h0);
        check("events cleared", 32'h0, rd_q);
        set_temp(8'h2A);
        apb(1'h0, APB_TEMP, 32'h0);
        check("temp register", 32'h2A, rd_q);
        ser_rd(SENSOR_DEV_ADDR, PTR_TEMP, rd_b);
        check("temp serial", 32'h2A, 32'(rd_b));
        foreach (AROWS[i]) begin
            ser_wr(SENSOR_DEV_ADDR, AROWS[i].ptr, AROWS[i].val);
            set_temp(AROWS[i].temp);
            check("alert pin", 32'(!AROWS[i].alert), 32'(ev_w));
        end
        ser_rd(SENSOR_DEV_ADDR, PTR_CFG, rd_b);
        check("config readback", 32'h4, 32'(rd_b));
        apb(1'h0, APB_IRQ_STAT, 32'h0);
        check("alert event", 32'h1, rd_q);
        check("irq masked", 32'h0, 32'(irq));
        apb(1'h1, APB_IRQ_MASK, 32'h1);
        @(posedge clk);
        check("irq raised", 32'h1, 32'(irq));
        apb(1'h1, APB_IRQ_STAT, 32'h1);
        @(posedge clk);
        check("irq cleared", 32'h0, 32'(irq));
        test_done();
    end
endmodule : mtd_thermal_desc_tb_top
